/* File: core/mic_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes it is included by bare name from the serial control port
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH
`define MIC_OFF_CFG 8'h00
`define MIC_OFF_FLAGS 8'h01
`define MIC_OFF_MASK 8'h03
`define MIC_OFF_PACE 8'h07
`define MIC_OFF_CHOFF 8'h08
`define MIC_OFF_PASS 8'h09
`define MIC_OFF_DEEP 8'h0A
`define MIC_OFF_SETUP 8'h0B
`define MIC_OFF_ACT 8'h0C
`define MIC_OFF_RES0 8'h20
`define MIC_OFF_RES7 8'h27
`define MIC_OFF_LIM0 8'h2A
`define MIC_OFF_LIM15 8'h39
`define MIC_OFF_MAKER 8'h3E
`define MIC_OFF_VER 8'h3F
`define MIC_CFG_RST 8'h08
`define MIC_ACT_RST 8'h02
`define MIC_CFG_RUN 0
`define MIC_CFG_AEN 1
`define MIC_CFG_ACLR 3
`define MIC_CFG_INIT 7
`define MIC_ACT_BUSY 0
`define MIC_ACT_NRDY 1
`define MIC_ADDR_LOW 7'h1D
`define MIC_ADDR_MID 7'h2D
`define MIC_ADDR_HIGH 7'h35
`define MIC_CLK_KHZ 100000
`define MIC_TIMEOUT_MS 35
`endif

/* File: core/mic_pkg.sv */
// types shared by the serial control port of the system monitor
// assumes nothing beyond a SystemVerilog compiler
package mic_pkg;
    typedef enum logic [2:0] {
        MIC_IDLE = 3'b000,
        MIC_RX = 3'b001,
        MIC_ACK = 3'b010,
        MIC_TX = 3'b011,
        MIC_MACK = 3'b100
    } mic_bus_t;
    typedef enum logic [1:0] {
        MIC_B_ADDR = 2'b00,
        MIC_B_PTR = 2'b01,
        MIC_B_DATA = 2'b10
    } mic_byte_t;
    typedef struct packed {
        logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
        logic [1:0] asl_m, asl_s, ash_m, ash_s;
        mic_bus_t state;
        mic_byte_t kind;
        logic rw, lo_next, mack, sda_drv, pass;
        logic [3:0] cnt;
        logic [7:0] shreg, tx, ptr;
        logic [23:0] to_cnt, sda_to_cnt, drv_cnt;
        logic [7:0] cfg, flags, mask, pace, choff, deep, setup;
        logic not_ready, alarm_n, run;
        logic [15:0][7:0] limits;
        logic [7:0][15:0] results;
    } mic_state_t;
endpackage

/* File: core/mic_ctl_port.sv */
// serial control port of an eight-channel system monitor: two-wire
// slave, register map, control register and alarm pin gating.
// assumes the converter and comparators run on mclk and talk to it
// through the result, alarm event and status ports.
//
// What this block does
// (R1) act only as bus slave; never start transfers or drive clock
// (R2) serial clock times only the serial logic; rest on internal clock
// (R3) write is address byte, pointer byte, then one data byte
// (R4) read without pointer byte returns currently pointed register
// (R5) arbitrary read: write pointer, repeated start, read data
// (R6) two tri-level pins pick one of nine slave addresses
// (R7) bus logic goes idle when clock or data stays low too long
// (R8) own data drive released after continuous low for the timeout
// (R9) host should not lean on timeout during deep shutdown
// (R10) control and status registers 8 bits, results 16 bits
// (R11) write to single-pass location starts one pass; write-only
// (R12) power-on loads listed defaults; results and limits undefined
// (R13) control register resets to run clear, alarm-clear set
// (R14) run bit runs loop; clear stops it, registers stay reachable
// (R15) clearing run bit does not release an asserted alarm pin
// (R16) alarm-enable bit gates the alarm pin
// (R17) alarm-clear bit forces pin inactive, halts loop, keeps flags
// (R18) init bit reloads defaults except results, limits; self-clears
// (R19) host waits start-up delay then polls until not-ready clears
// (R20) activity register resets with only not-ready set
// (R21) host programs setup, pace, disables, mask, limits first
// (R22) host sets run, clears alarm-clear, may enable alarm pin
// (R23) results stored in result register order while running
// (R24) reading alarm flags returns then clears them
// (R25) single-pass location stores nothing and reads zero
// (R26) result read gives upper byte first, then lower byte
`timescale 1ns/10ps
`include "mic_regs.svh"

module mic_ctl_port #(
    parameter int TIMEOUT_CYC = `MIC_TIMEOUT_MS * `MIC_CLK_KHZ,
    // identity values are arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] VERSION_CODE = 8'hA5
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_select_low,
    input wire logic [1:0] addr_select_high,
    output logic alarm_n,
    output logic loop_run,
    output logic single_pass_start,
    input wire logic [7:0] alarm_set,
    input wire logic conv_busy,
    input wire logic loop_ready,
    input wire logic res_we,
    input wire logic [2:0] res_sel,
    input wire logic [15:0] res_value,
    output logic [7:0] sampling_pace,
    output logic [7:0] channel_off_select,
    output logic [7:0] deep_sleep_control,
    output logic [7:0] reference_and_input_setup,
    output logic [127:0] threshold_values
);
    mic_pkg::mic_state_t s;
    mic_pkg::mic_state_t next_s;

    function automatic logic [6:0] own_addr(input logic [1:0] lo,
                                            input logic [1:0] hi);
        logic [6:0] base;
        base = `MIC_ADDR_HIGH;
        if (hi == 2'h0) begin
            base = `MIC_ADDR_LOW;
        end else if (hi == 2'h1) begin
            base = `MIC_ADDR_MID;
        end
        // codes 2 and 3 both count as a high pin
        if (lo == 2'h0) begin
            own_addr = base;
        end else if (lo == 2'h1) begin
            own_addr = base + 7'h01;
        end else begin
            own_addr = base + 7'h02;
        end
    endfunction

    function automatic logic [7:0] rd_byte(input mic_pkg::mic_state_t st,
                                           input logic busy);
        logic [7:0] li;
        logic [15:0] rv;
        li = st.ptr - `MIC_OFF_LIM0;
        rv = st.results[st.ptr[2:0]];
        rd_byte = 8'h00;
        case (st.ptr)
            `MIC_OFF_CFG: rd_byte = st.cfg;
            `MIC_OFF_FLAGS: rd_byte = st.flags;
            `MIC_OFF_MASK: rd_byte = st.mask;
            `MIC_OFF_PACE: rd_byte = st.pace;
            `MIC_OFF_CHOFF: rd_byte = st.choff;
            `MIC_OFF_PASS: rd_byte = 8'h00; // R25
            `MIC_OFF_DEEP: rd_byte = st.deep;
            `MIC_OFF_SETUP: rd_byte = st.setup;
            `MIC_OFF_ACT: rd_byte = {6'h00, st.not_ready, busy};
            `MIC_OFF_MAKER: rd_byte = MAKER_CODE;
            `MIC_OFF_VER: rd_byte = VERSION_CODE;
            // results and limits below; any other offset reads zero
            default: begin
                if (st.ptr >= `MIC_OFF_RES0 && st.ptr <= `MIC_OFF_RES7) begin
                    rd_byte = st.lo_next ? rv[7:0] : rv[15:8]; // R26
                end else if (st.ptr >= `MIC_OFF_LIM0
                             && st.ptr <= `MIC_OFF_LIM15) begin
                    rd_byte = st.limits[li[3:0]];
                end
            end
        endcase
    endfunction

    always_comb begin
        logic rise, fall, start, stop, clr_flags, wr, init;
        logic [7:0] li;
        next_s = s;
        // edges and start/stop use the settled copies only, so a data
        // change just after a clock fall is never taken for a start
        rise = s.scl_s & ~s.scl_p;
        fall = ~s.scl_s & s.scl_p;
        start = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
        stop = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
        clr_flags = 1'b0;
        wr = 1'b0;
        init = 1'b0;
        li = s.ptr - `MIC_OFF_LIM0;
        // serial lines are sampled as plain inputs on mclk
        next_s.scl_m = scl_in; // R2
        next_s.scl_s = s.scl_m;
        next_s.scl_p = s.scl_s;
        next_s.sda_m = sda_in;
        next_s.sda_s = s.sda_m;
        next_s.sda_p = s.sda_s;
        next_s.asl_m = addr_select_low;
        next_s.asl_s = s.asl_m;
        next_s.ash_m = addr_select_high;
        next_s.ash_s = s.ash_m;
        next_s.pass = 1'b0;

        case (s.state)
            mic_pkg::MIC_RX: begin
                if (rise) begin
                    next_s.shreg = {s.shreg[6:0], s.sda_s};
                    next_s.cnt = s.cnt + 4'h1;
                end else if (fall && s.cnt == 4'h8) begin
                    next_s.cnt = 4'h0;
                    next_s.sda_drv = 1'b1;
                    next_s.state = mic_pkg::MIC_ACK;
                    case (s.kind)
                        mic_pkg::MIC_B_ADDR: begin
                            next_s.rw = s.shreg[0];
                            next_s.lo_next = 1'b0;
                            if (s.shreg[7:1] != own_addr(s.asl_s, s.ash_s)) begin
                                next_s.sda_drv = 1'b0; // R6
                                next_s.state = mic_pkg::MIC_IDLE;
                            end
                        end
                        mic_pkg::MIC_B_PTR: next_s.ptr = s.shreg; // R3 R5
                        mic_pkg::MIC_B_DATA: wr = 1'b1; // R3
                        default: next_s.state = mic_pkg::MIC_IDLE;
                    endcase
                end
            end
            mic_pkg::MIC_ACK: begin
                if (fall) begin
                    next_s.sda_drv = 1'b0;
                    if (s.kind == mic_pkg::MIC_B_ADDR && s.rw) begin
                        // direct read of whatever the pointer holds
                        next_s.tx = rd_byte(s, conv_busy); // R4
                        next_s.sda_drv = ~next_s.tx[7];
                        next_s.state = mic_pkg::MIC_TX;
                        clr_flags = (s.ptr == `MIC_OFF_FLAGS); // R24
                    end else begin
                        // extra data bytes rewrite the same register
                        next_s.state = mic_pkg::MIC_RX;
                        next_s.kind = (s.kind == mic_pkg::MIC_B_ADDR) ?
                                      mic_pkg::MIC_B_PTR : mic_pkg::MIC_B_DATA;
                    end
                end
            end
            mic_pkg::MIC_TX: begin
                if (rise) begin
                    next_s.cnt = s.cnt + 4'h1;
                end else if (fall) begin
                    if (s.cnt == 4'h8) begin
                        next_s.sda_drv = 1'b0;
                        next_s.state = mic_pkg::MIC_MACK;
                    end else begin
                        next_s.tx = {s.tx[6:0], 1'b0};
                        next_s.sda_drv = ~s.tx[6];
                    end
                end
            end
            mic_pkg::MIC_MACK: begin
                if (rise) begin
                    next_s.mack = ~s.sda_s;
                end else if (fall) begin
                    next_s.cnt = 4'h0;
                    if (s.mack) begin
                        // the acknowledge releases the next byte
                        next_s.lo_next = ~s.lo_next; // R26
                        next_s.tx = rd_byte(next_s, conv_busy);
                        next_s.sda_drv = ~next_s.tx[7];
                        next_s.state = mic_pkg::MIC_TX;
                        clr_flags = (s.ptr == `MIC_OFF_FLAGS); // R24
                    end else begin
                        next_s.state = mic_pkg::MIC_IDLE;
                    end
                end
            end
            default: next_s.state = mic_pkg::MIC_IDLE;
        endcase

        // start and stop win over any byte in flight
        if (start) begin
            next_s.state = mic_pkg::MIC_RX;
            next_s.kind = mic_pkg::MIC_B_ADDR;
            next_s.cnt = 4'h0;
            next_s.sda_drv = 1'b0;
        end else if (stop) begin
            next_s.state = mic_pkg::MIC_IDLE;
            next_s.sda_drv = 1'b0;
        end

        // each line keeps its own low count, so a line that keeps
        // toggling never adds to the time charged against the other
        if (s.scl_s) begin
            next_s.to_cnt = 24'h000000;
        end else begin
            next_s.to_cnt = s.to_cnt + 24'h000001;
        end
        if (s.sda_s) begin
            next_s.sda_to_cnt = 24'h000000;
        end else begin
            next_s.sda_to_cnt = s.sda_to_cnt + 24'h000001;
        end
        if (s.sda_drv) begin
            next_s.drv_cnt = s.drv_cnt + 24'h000001;
        end else begin
            next_s.drv_cnt = 24'h000000;
        end
        // a master holding a line low forever cannot lock the bus
        if (s.to_cnt >= 24'(TIMEOUT_CYC - 1)
            || s.sda_to_cnt >= 24'(TIMEOUT_CYC - 1)) begin
            next_s.to_cnt = 24'h000000;
            next_s.sda_to_cnt = 24'h000000;
            next_s.state = mic_pkg::MIC_IDLE; // R7
            next_s.sda_drv = 1'b0;
        end
        // own low drive is cut on its own count whatever the master does,
        // so a stalled transfer can never pin the data line
        if (s.drv_cnt >= 24'(TIMEOUT_CYC - 1)) begin
            next_s.drv_cnt = 24'h000000;
            next_s.state = mic_pkg::MIC_IDLE;
            next_s.sda_drv = 1'b0; // R8
        end

        // writes to unmapped or read-only offsets fall through unused
        if (wr) begin
            case (s.ptr)
                `MIC_OFF_CFG: begin
                    next_s.cfg = s.shreg;
                    next_s.cfg[`MIC_CFG_INIT] = 1'b0; // R18
                    init = s.shreg[`MIC_CFG_INIT];
                end
                `MIC_OFF_MASK: next_s.mask = s.shreg;
                `MIC_OFF_PACE: next_s.pace = s.shreg;
                `MIC_OFF_CHOFF: next_s.choff = s.shreg;
                `MIC_OFF_PASS: next_s.pass = 1'b1; // R11 R25
                `MIC_OFF_DEEP: next_s.deep = s.shreg;
                `MIC_OFF_SETUP: next_s.setup = s.shreg;
                default: begin
                    if (s.ptr >= `MIC_OFF_LIM0 && s.ptr <= `MIC_OFF_LIM15) begin
                        next_s.limits[li[3:0]] = s.shreg;
                    end
                end
            endcase
        end

        // soft init leaves results and limits alone
        if (init) begin
            next_s.cfg = `MIC_CFG_RST; // R18
            next_s.mask = 8'h00;
            next_s.pace = 8'h00;
            next_s.choff = 8'h00;
            next_s.deep = 8'h00;
            next_s.setup = 8'h00;
            clr_flags = 1'b1;
        end
        // not-ready trails the loop by a cycle and init forces it on
        next_s.not_ready = init | ~loop_ready;

        // a new event in the clearing cycle is kept
        next_s.flags = (clr_flags ? 8'h00 : s.flags) | alarm_set; // R24
        if (res_we) begin
            next_s.results[res_sel] = res_value; // R23 R10
        end

        // alarm pin ignores the run bit on purpose
        next_s.alarm_n = ~(next_s.cfg[`MIC_CFG_AEN] // R16 R15
                           & ~next_s.cfg[`MIC_CFG_ACLR] // R17
                           & (|(next_s.flags & ~next_s.mask)));
        next_s.run = next_s.cfg[`MIC_CFG_RUN] // R14
                     & ~next_s.cfg[`MIC_CFG_ACLR]; // R17
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0; // R12
            // bus copies rest at the idle high level: no false edge
            s.scl_m <= 1'b1;
            s.scl_s <= 1'b1;
            s.scl_p <= 1'b1;
            s.sda_m <= 1'b1;
            s.sda_s <= 1'b1;
            s.sda_p <= 1'b1;
            s.cfg <= `MIC_CFG_RST; // R13
            s.not_ready <= 1'(`MIC_ACT_RST >> `MIC_ACT_NRDY); // R20
            s.alarm_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // open drain: only ever pulls low, never drives the clock line
    assign sda_out = 1'b0; // R1
    assign sda_oe = s.sda_drv; // R1
    assign alarm_n = s.alarm_n;
    assign loop_run = s.run;
    assign single_pass_start = s.pass;
    assign sampling_pace = s.pace;
    assign channel_off_select = s.choff;
    assign deep_sleep_control = s.deep;
    assign reference_and_input_setup = s.setup;
    assign threshold_values = s.limits;
endmodule

/* File: tb/mic_ctl_port_sva.sv */
// checker for the serial control port outputs
// assumes it is bound to mic_ctl_port and shares its timeout count
`timescale 1ns/10ps
module mic_ctl_port_sva #(
    parameter int TIMEOUT_CYC = 2000
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic alarm_n,
    input wire logic loop_run,
    input wire logic single_pass_start,
    input wire logic [7:0] alarm_set
);
    int oe_cnt;
    int lo_cnt;
    // run lengths of own data drive and of a low bus clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            oe_cnt <= 0;
            lo_cnt <= 0;
        end else begin
            oe_cnt <= sda_oe ? oe_cnt + 1 : 0;
            lo_cnt <= scl_in ? 0 : lo_cnt + 1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    // margin covers the two-stage synchroniser ahead of the counter
    a_bus_idle: assert property ((lo_cnt > TIMEOUT_CYC + 8) |-> !sda_oe)
        else $error("data held while clock stuck low");
    a_drive_bound: assert property (oe_cnt <= TIMEOUT_CYC + 8)
        else $error("own data drive outlasts timeout");
    a_reset_out: assert property ($rose(arst_n) |->
        alarm_n && !loop_run && !sda_oe && !single_pass_start)
        else $error("outputs wrong after reset");
    a_pass_pulse: assert property (single_pass_start |->
        !scl_in ##1 !single_pass_start)
        else $error("single pass pulse wrong");
    a_sda_edge: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
    a_run_change: assert property ($changed(loop_run) |-> !scl_in)
        else $error("run changed outside a bus write");
    a_alarm_fall: assert property ($fell(alarm_n) |->
        ($past(alarm_set) != 8'h00) || !scl_in)
        else $error("alarm raised without cause");
    a_alarm_rise: assert property ($rose(alarm_n) |-> !scl_in)
        else $error("alarm released without bus access");
endmodule

bind mic_ctl_port mic_ctl_port_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_sva (
    .mclk(mclk), .arst_n(arst_n), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .alarm_n(alarm_n), .loop_run(loop_run),
    .single_pass_start(single_pass_start), .alarm_set(alarm_set));

/* File: tb/mic_bfm.sv */
// two-wire bus master model: drives the clock, pulls data low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/10ps
module mic_bfm #(
    // four quarters of two mclk each give an 80 ns bus clock
    parameter int QTR = 2
) (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // clock rests high between frames, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (QTR) @(posedge mclk);
    endtask
    // data set mid low phase, read mid high phase
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        q();
        sda_low <= !b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
    endtask
    task automatic start();
        logic r;
        bit_io(1'b1, r);
        sda_low <= 1'b1;
        q();
    endtask
    task automatic stop();
        logic r;
        bit_io(1'b0, r);
        sda_low <= 1'b0;
        q();
    endtask
    task automatic xfer(input logic [7:0] w, input logic a,
                        output logic [7:0] r, output logic ar);
        for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
        bit_io(a, ar);
    endtask
    task automatic park(input int n);
        scl <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask
endmodule

/* File: tb/mic_ctl_port_tb.sv */
// self-checking bench for the serial control port
// assumes the master model and the bound checker
`timescale 1ns/10ps
`include "mic_regs.svh"
module mic_ctl_port_tb;
    localparam int TO = 400;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic scl, m_low, sda, sda_out, sda_oe, alarm_n, loop_run, pass;
    logic [1:0] asl = 2'b00, ash = 2'b00;
    logic [7:0] alarm_set = 8'h00;
    logic conv_busy = 1'b0, loop_ready = 1'b0, res_we = 1'b0;
    logic [2:0] res_sel = 3'h0;
    logic [15:0] res_value = 16'h0000, v, resv;
    logic [127:0] lim;
    logic [6:0] dev;
    logic [7:0] d, r, flg;
    logic k;
    logic [31:0] seed = 32'd98;
    logic [7:0] mdl [64] = '{default: 8'h00};
    logic [7:0] regs [7] = '{8'h03, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h2A, 8'h39};
    logic [6:0] base [3] = '{`MIC_ADDR_LOW, `MIC_ADDR_MID, `MIC_ADDR_HIGH};
    int n_mismatch = 0, compares = 0, npass = 0;
    always #5 mclk = ~mclk;
    assign sda = !(sda_oe || m_low);
    always @(posedge mclk) if (pass) npass++;
    mic_bfm i_mic_bfm (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));
    mic_ctl_port #(.TIMEOUT_CYC(TO)) i_mic_ctl_port (
        .mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_low(asl),
        .addr_select_high(ash), .alarm_n(alarm_n), .loop_run(loop_run),
        .single_pass_start(pass), .alarm_set(alarm_set),
        .conv_busy(conv_busy), .loop_ready(loop_ready), .res_we(res_we),
        .res_sel(res_sel), .res_value(res_value), .sampling_pace(),
        .channel_off_select(), .deep_sleep_control(),
        .reference_and_input_setup(), .threshold_values(lim));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        i_mic_bfm.start();
        i_mic_bfm.xfer({dev, 1'b0}, 1'b1, r, k);
        i_mic_bfm.xfer(a, 1'b1, r, k);
        i_mic_bfm.xfer(dat, 1'b1, r, k);
        chk(k, 1'b0);
        i_mic_bfm.stop();
        if (a inside {regs}) mdl[a[5:0]] = dat;
    endtask
    task automatic rd(input logic [7:0] a, input logic ptr, input int n);
        if (ptr) begin
            i_mic_bfm.start();
            i_mic_bfm.xfer({dev, 1'b0}, 1'b1, r, k);
            i_mic_bfm.xfer(a, 1'b1, r, k);
        end
        i_mic_bfm.start();
        i_mic_bfm.xfer({dev, 1'b1}, 1'b1, r, k);
        chk(k, 1'b0);
        v = 16'h0000;
        for (int i = 1; i <= n; i++) begin
            i_mic_bfm.xfer(8'hFF, i == n, r, k);
            v = {v[7:0], r};
        end
        i_mic_bfm.stop();
    endtask
    task automatic fire(input logic [7:0] f);
        alarm_set <= f;
        @(posedge mclk);
        alarm_set <= 8'h00;
        @(posedge mclk);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 9; i++) begin
            asl <= 2'(i % 3);
            ash <= 2'(i / 3);
            repeat (4) @(posedge mclk);
            dev = base[i / 3] + 7'(i % 3);
            rd(`MIC_OFF_ACT, 1'b1, 1);
            chk(v, 16'h0002);
        end
        i_mic_bfm.start();
        i_mic_bfm.xfer({dev ^ 7'h40, 1'b0}, 1'b1, r, k);
        i_mic_bfm.stop();
        chk(k, 1'b1);
        rd(`MIC_OFF_CFG, 1'b1, 1);
        chk(v, 16'h0008);
        loop_ready <= 1'b1;
        conv_busy <= 1'b1;
        rd(`MIC_OFF_ACT, 1'b1, 1);
        chk(v, 16'h0001);
        foreach (regs[j]) begin
            wr(regs[j], 8'(rnd()));
            rd(regs[j], 1'b1, 1);
            chk(v, {8'h00, mdl[regs[j][5:0]]});
        end
        rd(8'h39, 1'b0, 1);
        chk(v, {8'h00, mdl[6'h39]});
        chk(lim[127:120], mdl[6'h39]);
        wr(`MIC_OFF_PASS, 8'(rnd()));
        chk(16'(npass), 16'h0001);
        rd(`MIC_OFF_PASS, 1'b1, 1);
        chk(v, 16'h0000);
        resv = 16'(rnd());
        res_sel <= 3'h3;
        res_value <= resv;
        res_we <= 1'b1;
        @(posedge mclk);
        res_we <= 1'b0;
        rd(`MIC_OFF_RES0 + 8'h03, 1'b1, 2);
        chk(v, resv);
        wr(`MIC_OFF_MASK, 8'h00);
        wr(`MIC_OFF_CFG, 8'h09);
        wr(`MIC_OFF_CFG, 8'h03);
        chk(loop_run, 1'b1);
        flg = 8'(rnd()) | 8'h01;
        fire(flg);
        chk(alarm_n, 1'b0);
        wr(`MIC_OFF_CFG, 8'h02);
        chk({loop_run, alarm_n}, 2'b00);
        rd(`MIC_OFF_FLAGS, 1'b1, 1);
        chk(v, {8'h00, flg});
        chk(alarm_n, 1'b1);
        fire(flg);
        wr(`MIC_OFF_CFG, 8'h0A);
        chk({loop_run, alarm_n}, 2'b01);
        rd(`MIC_OFF_FLAGS, 1'b1, 1);
        chk(v, {8'h00, flg});
        wr(`MIC_OFF_CFG, 8'h01);
        fire(flg);
        chk(alarm_n, 1'b1);
        wr(`MIC_OFF_CFG, 8'h80);
        rd(`MIC_OFF_CFG, 1'b1, 1);
        chk(v, 16'h0008);
        rd(`MIC_OFF_FLAGS, 1'b1, 1);
        chk(v, 16'h0000);
        rd(`MIC_OFF_PACE, 1'b1, 1);
        chk(v, 16'h0000);
        rd(8'h39, 1'b1, 1);
        chk(v, {8'h00, mdl[6'h39]});
        rd(`MIC_OFF_RES0 + 8'h03, 1'b1, 2);
        chk(v, resv);
        // stall the clock inside the address acknowledge
        i_mic_bfm.start();
        for (int i = 6; i >= 0; i--) i_mic_bfm.bit_io(dev[i], r[0]);
        i_mic_bfm.bit_io(1'b0, r[0]);
        i_mic_bfm.park(10);
        chk(sda_oe, 1'b1);
        i_mic_bfm.park(TO + 20);
        chk(sda_oe, 1'b0);
        i_mic_bfm.stop();
        rd(`MIC_OFF_CFG, 1'b1, 1);
        chk(v, 16'h0008);
        conclude();
    end
endmodule
